// ### logic/pcr_clkdiv.sv
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_clkdiv (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control
	input wire logic run,
	input wire pcr_pkg::pcr_div_t sel,
	// divided clock enable and active ratio
	output logic tick,
	output pcr_pkg::pcr_div_t act
);
	import pcr_pkg::*;

	logic [1:0] cnt_reg;
	logic tick_reg;
	pcr_div_t act_reg;

	function automatic logic [1:0] last_count(input pcr_div_t s);
		unique case (s)
			`PCR_DIV_FULL: last_count = 2'h0;
			`PCR_DIV_HALF: last_count = 2'h1;
			default: last_count = 2'h3;
		endcase
	endfunction

	// ratio is only taken at a period boundary
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 2'h0;
			act_reg <= `PCR_DIV_QUARTER; // RULE_10
		end else if (!run) begin
			cnt_reg <= 2'h0;
		end else if (cnt_reg == 2'h0) begin
			cnt_reg <= last_count(sel); // RULE_09
			act_reg <= sel; // RULE_15
		end else begin
			cnt_reg <= cnt_reg - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_reg <= 1'h0;
		end else begin
			tick_reg <= run && (cnt_reg == 2'h0);
		end
	end

	assign tick = tick_reg;
	assign act = act_reg;

	property p_div_full;
		@(posedge clk) disable iff (!arst_n)
		tick_reg && act_reg == `PCR_DIV_FULL && run |=> tick_reg;
	endproperty
	a_div_full: assert property (p_div_full) else $error("full rate missed a tick"); // RULE_09

	property p_div_half;
		@(posedge clk) disable iff (!arst_n)
		tick_reg && act_reg == `PCR_DIV_HALF && run |=> !tick_reg ##1 (tick_reg || !$past(run));
	endproperty
	a_div_half: assert property (p_div_half) else $error("half rate spacing wrong"); // RULE_09

	property p_div_quarter;
		@(posedge clk) disable iff (!arst_n)
		tick_reg && act_reg == `PCR_DIV_QUARTER |=> !tick_reg [*3];
	endproperty
	a_div_quarter: assert property (p_div_quarter) else $error("quarter period shortened"); // RULE_10

	property p_div_boundary;
		@(posedge clk) disable iff (!arst_n)
		$changed(act_reg) |-> tick_reg;
	endproperty
	a_div_boundary: assert property (p_div_boundary) else $error("ratio changed mid period"); // RULE_15

endmodule

// ### logic/pcr_params.svh
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// register port
`define PCR_ADDR_W 8
`define PCR_DATA_W 32
`define PCR_OFF_MAP 8'h00
`define PCR_OFF_MODE 8'h04
`define PCR_OFF_PEN 8'h08
`define PCR_OFF_DIV 8'h0C
`define PCR_OFF_WEN 8'h10
`define PCR_OFF_STAT 8'h14

// field positions
`define PCR_MODE_IDLE_BIT 0
`define PCR_MODE_PDOWN_BIT 1
`define PCR_MAP_SRAM_BIT 0

// sizes
`define PCR_NPERIPH 8
`define PCR_NEXT 4
`define PCR_CNT_W 12

// reset values
`define PCR_MAP_RST 1'h0
`define PCR_PEN_RST 8'hFF
`define PCR_WEN_RST 4'h0

// divide codes
`define PCR_DIV_QUARTER 2'h0
`define PCR_DIV_FULL 2'h1
`define PCR_DIV_HALF 2'h2

// timing
`define PCR_CLK_NS 25
`define PCR_WAKE_NS 50000
`define PCR_WAKE_CYC ((`PCR_WAKE_NS + `PCR_CLK_NS - 1) / `PCR_CLK_NS)

`endif

// ### logic/pcr_pkg.sv
`include "pcr_params.svh"

package pcr_pkg;

	typedef logic [1:0] pcr_div_t;

	typedef enum logic [3:0] {
		PCR_ST_RUN = 4'h1,
		PCR_ST_IDLE = 4'h2,
		PCR_ST_PDOWN = 4'h4,
		PCR_ST_WAKE = 4'h8
	} pcr_state_e;

	typedef struct packed {
		logic [`PCR_ADDR_W-1:0] addr;
		logic [`PCR_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pcr_req_s;

	typedef struct packed {
		logic osc_en;
		logic cpu_clk_en;
		logic pll_keep;
		logic pin_hold;
	} pcr_pwr_s;

endpackage

// ### logic/pcr_top.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "pcr_params.svh"

// Function
// [RULE_01] vectors at address zero come from flash or SRAM, chosen by software.
// [RULE_02] idle halts execution until a reset or an interrupt arrives.
// [RULE_03] peripheral clocks keep running in idle so peripherals can interrupt.
// [RULE_04] idle stops clocks to processor, memories and internal buses.
// [RULE_05] power-down stops the oscillator and every internal clock.
// [RULE_06] power-down keeps all state and holds output pins at their levels.
// [RULE_07] power-down ends on reset or a clockless wake interrupt.
// [RULE_08] each peripheral has its own clock enable set by software.
// [RULE_09] peripheral clock runs at full, half or quarter processor rate.
// [RULE_10] after reset the peripheral clock runs at quarter rate.
// [RULE_11] divider control sits on the peripheral bus, usable at reset ratio.
// [RULE_12] a running PLL stays running through idle.
// [RULE_13] every power-down wake runs the wake-up timer before execution.
// [RULE_14] enabled external interrupt inputs can end power-down.
// [RULE_15] divide ratio changes only at a divided-clock period boundary.

module pcr_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire pcr_pkg::pcr_req_s req,
	output logic [`PCR_DATA_W-1:0] rdata,
	// system events
	input wire logic irq_pend,
	input wire logic pll_running,
	input wire logic [`PCR_NEXT-1:0] ext_wake_pin,
	// clock, power and vector map controls
	output pcr_pkg::pcr_pwr_s pwr,
	output logic vec_sram,
	output logic [`PCR_NPERIPH-1:0] periph_clk_en,
	output logic pclk_tick
);
	import pcr_pkg::*;

	pcr_state_e state_reg;
	pcr_state_e state_next;
	logic map_reg;
	logic [`PCR_NPERIPH-1:0] pen_reg;
	pcr_div_t div_reg;
	logic [`PCR_NEXT-1:0] wen_reg;
	logic [`PCR_NEXT-1:0] cause_reg;
	logic [`PCR_NEXT-1:0] wake_s1_reg;
	logic [`PCR_NEXT-1:0] wake_s2_reg;
	logic pll_idle_reg;
	logic [`PCR_DATA_W-1:0] rdata_reg;
	pcr_pwr_s pwr_reg;
	logic [`PCR_NPERIPH-1:0] pclk_en_reg;
	logic [`PCR_NPERIPH-1:0] pen_next;
	logic [`PCR_NEXT-1:0] wake_hit;
	logic wr_map;
	logic wr_mode;
	logic wr_pen;
	logic wr_div;
	logic wr_wen;
	logic wr_stat;
	logic tmr_start;
	logic tmr_done;
	logic div_run;
	logic div_tick;
	pcr_div_t div_act;

	assign wr_map = req.wr && (req.addr == `PCR_OFF_MAP);
	assign wr_mode = req.wr && (req.addr == `PCR_OFF_MODE);
	assign wr_pen = req.wr && (req.addr == `PCR_OFF_PEN);
	assign wr_div = req.wr && (req.addr == `PCR_OFF_DIV);
	assign wr_wen = req.wr && (req.addr == `PCR_OFF_WEN);
	assign wr_stat = req.wr && (req.addr == `PCR_OFF_STAT);
	assign wake_hit = wake_s2_reg & wen_reg;
	assign pen_next = wr_pen ? req.wdata[`PCR_NPERIPH-1:0] : pen_reg;

	// wake pins come from outside the clock domain
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_s1_reg <= '0;
			wake_s2_reg <= '0;
		end else begin
			wake_s1_reg <= ext_wake_pin;
			wake_s2_reg <= wake_s1_reg;
		end
	end

	// power mode sequencing
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PCR_ST_RUN: begin
				if (wr_mode && req.wdata[`PCR_MODE_PDOWN_BIT]) begin
					state_next = PCR_ST_PDOWN; // RULE_05
				end else if (wr_mode && req.wdata[`PCR_MODE_IDLE_BIT]) begin
					state_next = PCR_ST_IDLE; // RULE_02
				end
			end
			PCR_ST_IDLE: begin
				if (irq_pend) begin
					state_next = PCR_ST_RUN; // RULE_02
				end
			end
			PCR_ST_PDOWN: begin
				if (|wake_hit) begin
					state_next = PCR_ST_WAKE; // RULE_07 RULE_14
				end
			end
			PCR_ST_WAKE: begin
				if (tmr_done) begin
					state_next = PCR_ST_RUN; // RULE_13
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= PCR_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tmr_start = (state_reg == PCR_ST_PDOWN) && (state_next == PCR_ST_WAKE);

	pcr_waketmr u_waketmr (
		.clk(clk),
		.arst_n(arst_n),
		.start(tmr_start),
		.done(tmr_done)
	);

	// clock gating outputs follow the next state so they change with it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_reg <= '{osc_en: 1'h1, cpu_clk_en: 1'h1, pll_keep: 1'h0, pin_hold: 1'h0};
		end else begin
			pwr_reg.cpu_clk_en <= (state_next == PCR_ST_RUN); // RULE_04
			pwr_reg.osc_en <= (state_next != PCR_ST_PDOWN); // RULE_05
			pwr_reg.pin_hold <= (state_next == PCR_ST_PDOWN) || (state_next == PCR_ST_WAKE); // RULE_06
			if (state_next == PCR_ST_IDLE && state_reg == PCR_ST_RUN) begin
				pwr_reg.pll_keep <= pll_running; // RULE_12
			end else if (state_next != PCR_ST_IDLE) begin
				pwr_reg.pll_keep <= 1'h0;
			end
		end
	end

	// remembers whether the pll ran when idle began
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pll_idle_reg <= 1'h0;
		end else if (state_next == PCR_ST_IDLE && state_reg == PCR_ST_RUN) begin
			pll_idle_reg <= pll_running;
		end
	end

	// per-peripheral clock enables, all off while the oscillator is down
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pclk_en_reg <= `PCR_PEN_RST;
		end else if (state_next == PCR_ST_RUN || state_next == PCR_ST_IDLE) begin
			pclk_en_reg <= pen_next; // RULE_08 RULE_03
		end else begin
			pclk_en_reg <= '0; // RULE_05
		end
	end

	// run follows the next state so no last tick leaks into power-down
	assign div_run = (state_next == PCR_ST_RUN) || (state_next == PCR_ST_IDLE); // RULE_03 RULE_05

	pcr_clkdiv u_clkdiv (
		.clk(clk),
		.arst_n(arst_n),
		.run(div_run),
		.sel(div_reg),
		.tick(div_tick),
		.act(div_act)
	);

	// software registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			map_reg <= `PCR_MAP_RST;
		end else if (wr_map) begin
			map_reg <= req.wdata[`PCR_MAP_SRAM_BIT]; // RULE_01
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pen_reg <= `PCR_PEN_RST;
		end else begin
			pen_reg <= pen_next; // RULE_08
		end
	end

	// the register port runs on clk, so it works at any divide ratio
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= `PCR_DIV_QUARTER; // RULE_10
		end else if (wr_div) begin
			div_reg <= req.wdata[1:0]; // RULE_11
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wen_reg <= `PCR_WEN_RST;
		end else if (wr_wen) begin
			wen_reg <= req.wdata[`PCR_NEXT-1:0]; // RULE_14
		end
	end

	// wake cause bits: write one to clear, a new wake wins over the clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cause_reg <= '0;
		end else begin
			cause_reg <= (cause_reg & ~(wr_stat ? req.wdata[`PCR_NEXT-1:0] : '0)) |
				(tmr_start ? wake_hit : '0);
		end
	end

	// read data stand in the cycle after the strobe only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= '0;
		end else if (req.rd) begin
			unique case (req.addr)
				`PCR_OFF_MAP: rdata_reg <= {31'h0, map_reg};
				`PCR_OFF_MODE: rdata_reg <= {30'h0, state_reg == PCR_ST_PDOWN, state_reg == PCR_ST_IDLE};
				`PCR_OFF_PEN: rdata_reg <= {24'h0, pen_reg};
				`PCR_OFF_DIV: rdata_reg <= {30'h0, div_reg};
				`PCR_OFF_WEN: rdata_reg <= {28'h0, wen_reg};
				`PCR_OFF_STAT: rdata_reg <= {20'h0, div_act, pll_idle_reg, 1'h0, cause_reg, state_reg};
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	assign rdata = rdata_reg;
	assign pwr = pwr_reg;
	assign vec_sram = map_reg;
	assign periph_clk_en = pclk_en_reg;
	assign pclk_tick = div_tick;

	property p_map;
		@(posedge clk) disable iff (!arst_n)
		wr_map |=> vec_sram == $past(req.wdata[`PCR_MAP_SRAM_BIT]);
	endproperty
	a_map: assert property (p_map) else $error("vector map not updated"); // RULE_01

	property p_idle_hold;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_IDLE && !irq_pend |=> state_reg == PCR_ST_IDLE;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle left without interrupt"); // RULE_02

	property p_idle_pclk;
		@(posedge clk) disable iff (!arst_n)
		(state_reg == PCR_ST_IDLE) [*5] |-> pclk_tick || $past(pclk_tick) || $past(pclk_tick, 2) ||
			$past(pclk_tick, 3);
	endproperty
	a_idle_pclk: assert property (p_idle_pclk) else $error("peripheral clock stopped in idle"); // RULE_03

	property p_idle_cpu;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_IDLE |-> !pwr.cpu_clk_en && pwr.osc_en;
	endproperty
	a_idle_cpu: assert property (p_idle_cpu) else $error("processor clocked in idle"); // RULE_04

	property p_pdown_clk;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_PDOWN |-> !pwr.osc_en && !pwr.cpu_clk_en && periph_clk_en == '0 && !pclk_tick;
	endproperty
	a_pdown_clk: assert property (p_pdown_clk) else $error("clock alive in power-down"); // RULE_05

	property p_pdown_hold;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_PDOWN |-> pwr.pin_hold && $stable(vec_sram) && $stable(pen_reg);
	endproperty
	a_pdown_hold: assert property (p_pdown_hold) else $error("state lost in power-down"); // RULE_06

	property p_pdown_wake;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_PDOWN && (|(wake_s2_reg & wen_reg)) |=> state_reg == PCR_ST_WAKE ##1 pwr.osc_en;
	endproperty
	a_pdown_wake: assert property (p_pdown_wake) else $error("enabled wake pin ignored"); // RULE_14

	property p_pdown_stay;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_PDOWN && wake_hit == '0 |=> state_reg == PCR_ST_PDOWN;
	endproperty
	a_pdown_stay: assert property (p_pdown_stay) else $error("power-down left without cause"); // RULE_07

	property p_pen;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_RUN |-> periph_clk_en == pen_reg;
	endproperty
	a_pen: assert property (p_pen) else $error("peripheral enable mismatch"); // RULE_08

	property p_wake_timer;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_WAKE && !tmr_done |=> state_reg == PCR_ST_WAKE && !pwr.cpu_clk_en;
	endproperty
	a_wake_timer: assert property (p_wake_timer) else $error("execution resumed before wake timer"); // RULE_13

	property p_pll_keep;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_IDLE && pll_idle_reg |-> pwr.pll_keep;
	endproperty
	a_pll_keep: assert property (p_pll_keep) else $error("pll released in idle"); // RULE_12

	property p_div_write;
		@(posedge clk) disable iff (!arst_n)
		wr_div |=> div_reg == $past(req.wdata[1:0]);
	endproperty
	a_div_write: assert property (p_div_write) else $error("divider write lost"); // RULE_11

	property p_idle_exit;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_IDLE && irq_pend |=> state_reg == PCR_ST_RUN && pwr.cpu_clk_en;
	endproperty
	a_idle_exit: assert property (p_idle_exit) else $error("interrupt did not end idle"); // RULE_02

	property p_pdown_prio;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_RUN && wr_mode && req.wdata[`PCR_MODE_PDOWN_BIT] |=>
			state_reg == PCR_ST_PDOWN && !pwr.osc_en;
	endproperty
	a_pdown_prio: assert property (p_pdown_prio) else $error("power-down request not taken"); // RULE_05

	property p_wake_done;
		@(posedge clk) disable iff (!arst_n)
		state_reg == PCR_ST_WAKE && tmr_done |=> state_reg == PCR_ST_RUN && pwr.cpu_clk_en && !pwr.pin_hold &&
			periph_clk_en == pen_reg;
	endproperty
	a_wake_done: assert property (p_wake_done) else $error("wake end did not resume run"); // RULE_13

	property p_cause_set;
		@(posedge clk) disable iff (!arst_n)
		tmr_start |=> (cause_reg & $past(wake_hit)) == $past(wake_hit);
	endproperty
	a_cause_set: assert property (p_cause_set) else $error("wake cause not recorded"); // RULE_14

endmodule

// ### logic/pcr_waketmr.sv
`timescale 1ns/1ps
`include "pcr_params.svh"

module pcr_waketmr (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// control
	input wire logic start,
	// expiry pulse
	output logic done
);
	import pcr_pkg::*;

	logic [`PCR_CNT_W-1:0] cnt_reg;
	logic done_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
		end else if (start) begin
			cnt_reg <= `PCR_CNT_W'(`PCR_WAKE_CYC); // RULE_13
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - `PCR_CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done_reg <= 1'h0;
		end else begin
			done_reg <= !start && (cnt_reg == `PCR_CNT_W'(1));
		end
	end

	assign done = done_reg;

	property p_tmr_load;
		@(posedge clk) disable iff (!arst_n)
		start |=> cnt_reg == `PCR_CNT_W'(`PCR_WAKE_CYC) && !done_reg;
	endproperty
	a_tmr_load: assert property (p_tmr_load) else $error("wake timer not loaded"); // RULE_13

endmodule

// ### testbench/pcr_partner.sv
`timescale 1ns/1ps
`include "pcr_params.svh"

// processor-side peripherals: interrupt after idle ticks, wake pin pulses
module pcr_partner (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// observed device outputs
	input wire logic cpu_clk_en,
	input wire logic pclk_tick,
	// bench commands
	input wire logic irq_arm,
	input wire logic irq_force,
	input wire logic wake_go,
	input wire logic [1:0] wake_idx,
	// device inputs
	output logic irq_pend,
	output logic [`PCR_NEXT-1:0] ext_wake_pin
);
	logic [1:0] tick_cnt;
	logic irq_tick;
	logic go_d;
	logic [2:0] pin_cnt;

	// timer peripheral counts peripheral ticks while the core sleeps
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_cnt <= 2'h0;
			irq_tick <= 1'b0;
		end else if (!irq_arm || cpu_clk_en) begin
			tick_cnt <= 2'h0;
			irq_tick <= 1'b0;
		end else if (pclk_tick) begin
			if (tick_cnt == 2'h2)
				irq_tick <= 1'b1;
			else
				tick_cnt <= tick_cnt + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			go_d <= 1'b0;
			pin_cnt <= 3'h0;
		end else begin
			go_d <= wake_go;
			if (wake_go && !go_d)
				pin_cnt <= 3'h4;
			else if (pin_cnt != 3'h0)
				pin_cnt <= pin_cnt - 3'h1;
		end
	end

	assign irq_pend = irq_tick | irq_force;
	assign ext_wake_pin = (pin_cnt != 3'h0) ? (`PCR_NEXT'(1) << wake_idx) : '0;
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`include "pcr_params.svh"

module tb_top;
	import pcr_pkg::*;
	logic clk, arst_n, pll_running, irq_arm, irq_force, wake_go, rd_d;
	logic [1:0] wake_idx;
	pcr_req_s req;
	logic [`PCR_DATA_W-1:0] rdata, v;
	logic irq_pend, vec_sram, pclk_tick;
	logic [`PCR_NEXT-1:0] ext_wake_pin;
	pcr_pwr_s pwr;
	logic [`PCR_NPERIPH-1:0] periph_clk_en;
	logic [31:0] exp_q[$];
	integer error_cnt, check_count, seed, gap, n, c, k, prev;
	integer codes[4] = '{1, 2, 3, 0};
	integer want[4] = '{1, 2, 4, 4};

	pcr_top dut(.clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .irq_pend(irq_pend),
		.pll_running(pll_running), .ext_wake_pin(ext_wake_pin), .pwr(pwr), .vec_sram(vec_sram),
		.periph_clk_en(periph_clk_en), .pclk_tick(pclk_tick));
	pcr_partner partner(.clk(clk), .arst_n(arst_n), .cpu_clk_en(pwr.cpu_clk_en), .pclk_tick(pclk_tick),
		.irq_arm(irq_arm), .irq_force(irq_force), .wake_go(wake_go), .wake_idx(wake_idx),
		.irq_pend(irq_pend), .ext_wake_pin(ext_wake_pin));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task give_verdict;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task tmo(input string m);
		error_cnt++;
		$display("[FAIL] %0t timeout %s", $time, m);
		give_verdict;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// the expected read value is noted before the strobe goes out
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
	endtask

	always @(negedge clk) begin
		if (rd_d) begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0, "read without note");
			else
				chk(rdata, exp_q.pop_front(), "read");
		end
		rd_d = req.rd;
	end

	// cycles between two consecutive peripheral ticks
	task tick_gap;
		n = 0;
		while (pclk_tick !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 50) tmo("tick");
		end
		gap = 0;
		do begin
			@(posedge clk);
			#1;
			gap++;
			if (gap > 50) tmo("gap");
		end while (pclk_tick !== 1'b1);
	endtask

	task wait_cpu(input integer lim);
		c = 0;
		while (pwr.cpu_clk_en !== 1'b1) begin
			@(posedge clk);
			#1;
			c++;
			if (c > lim) tmo("cpu clock");
		end
	endtask

	task do_reset;
		arst_n <= 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		#1;
	endtask

	initial begin
		seed = 80989;
		error_cnt = 0;
		check_count = 0;
		rd_d = 1'b0;
		req = '0;
		{pll_running, irq_arm, irq_force, wake_go} = 4'h0;
		wake_idx = 2'h0;
		arst_n = 1'b0;
		do_reset;
		chk(pwr, 4'hC, "pwr reset");
		chk(vec_sram, 1'h0, "map reset");
		chk(periph_clk_en, 8'hFF, "pen reset");
		rd(`PCR_OFF_DIV, 32'h0);
		rd(`PCR_OFF_STAT, 32'h1);
		rd(8'h20, 32'h0);
		tick_gap;
		tick_gap;
		chk(gap, 4, "reset ratio");
		for (k = 0; k < 4; k++) begin
			v = $random(seed);
			wr(`PCR_OFF_PEN, v);
			rd(`PCR_OFF_PEN, {24'h0, v[7:0]});
			chk(periph_clk_en, v[7:0], "pen");
			wr(`PCR_OFF_MAP, {31'h0, v[8]});
			#1;
			chk(vec_sram, v[8], "map");
		end
		wr(`PCR_OFF_PEN, 32'hFF);
		prev = 4;
		for (k = 0; k < 4; k++) begin
			wr(`PCR_OFF_DIV, codes[k]);
			repeat (6) begin
				tick_gap;
				chk(gap == prev || gap == want[k], 1'b1, "glitch");
			end
			chk(gap, want[k], "ratio");
			rd(`PCR_OFF_DIV, codes[k]);
			prev = want[k];
		end
		wr(`PCR_OFF_DIV, 32'h1);
		do_reset;
		tick_gap;
		tick_gap;
		chk(gap, 4, "ratio after reset");
		@(posedge clk);
		pll_running <= 1'b1;
		irq_arm <= 1'b1;
		wr(`PCR_OFF_MODE, 32'h1);
		@(posedge clk);
		#1;
		chk(pwr.cpu_clk_en, 1'h0, "idle gate");
		chk(pwr.pll_keep, 1'h1, "pll kept");
		rd(`PCR_OFF_MODE, 32'h1);
		wait_cpu(60);
		chk(c >= 6, 1'b1, "idle too short");
		irq_arm <= 1'b0;
		wr(`PCR_OFF_WEN, 32'h2);
		rd(`PCR_OFF_WEN, 32'h2);
		wr(`PCR_OFF_MODE, 32'h2);
		@(posedge clk);
		#1;
		chk({pwr.osc_en, pwr.cpu_clk_en, periph_clk_en}, 10'h0, "pdown clocks");
		chk(pwr.pin_hold, 1'h1, "pin hold");
		repeat (2) @(posedge clk);
		irq_force <= 1'b1;
		wake_go <= 1'b1;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			#1;
			n += pclk_tick;
		end
		chk(n, 0, "pdown ticks");
		chk(pwr.osc_en, 1'h0, "irq or masked pin woke");
		@(posedge clk);
		irq_force <= 1'b0;
		wake_go <= 1'b0;
		wake_idx <= 2'h1;
		@(posedge clk);
		wake_go <= 1'b1;
		n = 0;
		while (pwr.osc_en !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 20) tmo("osc");
		end
		chk({pwr.cpu_clk_en, pwr.pin_hold}, 2'h1, "wake start");
		wait_cpu(2100);
		chk(c >= 1990, 1'b1, "wake timer short");
		chk(pwr.pin_hold, 1'h0, "pins released");
		chk(periph_clk_en, 8'hFF, "pen restored");
		rd(`PCR_OFF_PEN, 32'hFF);
		rd(`PCR_OFF_STAT, 32'h221);
		wr(`PCR_OFF_STAT, 32'h2);
		rd(`PCR_OFF_STAT, 32'h201);
		rd(`PCR_OFF_MODE, 32'h0);
		repeat (3) @(posedge clk);
		give_verdict;
	end
endmodule
